// ### rtl/sptmr_top.sv
// Setpoint timer with manual and automatic reset modes, pulse outputs and count back-up.
`timescale 1ns/1ps
module sptmr_top #(
	parameter int SEC_CYCLES   = sptmr_pkg::CLK_HZ * sptmr_pkg::SEC_UNIT_S,
	parameter int PULSE_CYCLES = sptmr_pkg::CLK_HZ / sptmr_pkg::MS_PER_S * sptmr_pkg::PULSE_UNIT_MS
) (
	input  wire logic                    core_clk_i,
	input  wire logic                    resetn_i,
	input  wire logic                    run_i,
	input  wire logic                    man_reset_i,
	input  wire logic                    power_fail_i,
	input  wire logic [sptmr_pkg::AW-1:0] reg_addr_i,
	input  wire logic [sptmr_pkg::DW-1:0] reg_wdata_i,
	input  wire logic                    reg_wr_i,
	input  wire logic                    reg_rd_i,
	output logic      [sptmr_pkg::DW-1:0] reg_rdata_o,
	output logic                         out1_o,
	output logic                         out2_o,
	output logic      [sptmr_pkg::CW-1:0] disp_o,
	output logic                         irq_o
);
	import sptmr_pkg::*;

	// ==========================================================
	// Pin synchronisers
	logic [2:0] s1_r, s2_r, s3_r;
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			s1_r <= 3'h0;
			s2_r <= 3'h0;
			s3_r <= 3'h0;
		end else begin
			s1_r <= {power_fail_i, man_reset_i, run_i};
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	logic run_lvl, mrst_ev, pf_ev;
	assign run_lvl = s2_r[0];
	assign mrst_ev = s2_r[1] & ~s3_r[1];
	assign pf_ev   = s2_r[2] & ~s3_r[2];

	// ==========================================================
	// Registers and decode
	logic [CTRL_W-1:0] ctrl_r;
	logic [CW-1:0]     sp1_r, sp2_r, count_r, count_nxt;
	logic [PW-1:0]     pt1_r, pt2_r;
	logic [DW-1:0]     total_r, total_nxt, rdata_nxt;
	logic [ST_W-1:0]   status_r, mask_r, events;
	logic [1:0]        act_r, act_nxt, p_done;
	logic              halt_r, halt_nxt, show_r, show_nxt;
	sptmr_state_t      state_r, state_nxt;
	sptmr_mode_t       mode;
	logic              sexa, down, alarm1, alarm2, bk_en, soft_rst;
	logic              wr_ctrl, wr_sp1, wr_sp2, wr_pt1, wr_pt2, wr_stat, wr_mask;
	logic              sp_ok, pt_ok;
	sptmr_mem_if       memif ();

	assign mode     = sptmr_mode_t'(ctrl_r[CB_MODE +: 3]);
	assign sexa     = ctrl_r[CB_SCALE +: 2] != SC_SEC;
	assign down     = ctrl_r[CB_DOWN] == DIR_DOWN;
	assign alarm1   = ctrl_r[CB_AL1];
	assign alarm2   = ctrl_r[CB_AL2];
	assign bk_en    = ctrl_r[CB_BKEN];
	assign wr_ctrl  = reg_wr_i && reg_addr_i == A_CTRL;
	assign wr_sp1   = reg_wr_i && reg_addr_i == A_SP1;
	assign wr_sp2   = reg_wr_i && reg_addr_i == A_SP2;
	assign wr_pt1   = reg_wr_i && reg_addr_i == A_PT1;
	assign wr_pt2   = reg_wr_i && reg_addr_i == A_PT2;
	assign wr_stat  = reg_wr_i && reg_addr_i == A_STATUS;
	assign wr_mask  = reg_wr_i && reg_addr_i == A_MASK;
	assign soft_rst = wr_ctrl && reg_wdata_i[CB_SRST];
	// Setpoints outside the scale's range are refused and flagged.
	assign sp_ok = reg_wdata_i[DW-1:CW] == '0 && (sexa ?
		(reg_wdata_i[CW-1:LO_W] <= HM_HI_MAX && reg_wdata_i[LO_W-1:0] <= LO_MAX) :
		reg_wdata_i[CW-1:0] <= SEC_MAX);
	assign pt_ok = reg_wdata_i[DW-1:PW] == '0 && reg_wdata_i[PW-1:0] <= PT_MAX;

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			ctrl_r <= CTRL_RST;
			sp1_r  <= SP_RST;
			sp2_r  <= SP_RST;
			pt1_r  <= PT_RST;
			pt2_r  <= PT_RST;
			mask_r <= ST_RST;
		end else begin
			if (wr_ctrl) ctrl_r <= reg_wdata_i[CTRL_W-1:0];
			if (wr_sp1 && sp_ok) sp1_r <= reg_wdata_i[CW-1:0];
			if (wr_sp2 && sp_ok) sp2_r <= reg_wdata_i[CW-1:0];
			if (wr_pt1 && pt_ok) pt1_r <= reg_wdata_i[PW-1:0];
			if (wr_pt2 && pt_ok) pt2_r <= reg_wdata_i[PW-1:0];
			if (wr_mask) mask_r <= reg_wdata_i[ST_W-1:0];
		end
	end

	always_comb begin
		rdata_nxt = DW_ZERO;
		if (reg_addr_i == A_CTRL) rdata_nxt = DW'(ctrl_r);
		else if (reg_addr_i == A_SP1) rdata_nxt = DW'(sp1_r);
		else if (reg_addr_i == A_SP2) rdata_nxt = DW'(sp2_r);
		else if (reg_addr_i == A_PT1) rdata_nxt = DW'(pt1_r);
		else if (reg_addr_i == A_PT2) rdata_nxt = DW'(pt2_r);
		else if (reg_addr_i == A_COUNT) rdata_nxt = DW'(count_r);
		else if (reg_addr_i == A_TOTAL) rdata_nxt = total_r;
		else if (reg_addr_i == A_STATUS) rdata_nxt = DW'(status_r);
		else if (reg_addr_i == A_MASK) rdata_nxt = DW'(mask_r);
		else if (reg_addr_i == A_STATE) rdata_nxt = DW'({state_r, show_r, halt_r, act_r, run_lvl});
	end

	// ==========================================================
	// Time bases
	logic [SECW-1:0] sec_cnt_r;
	logic [MINW-1:0] min_cnt_r;
	logic [PLSW-1:0] pls_cnt_r;
	logic            sec_tick, min_tick, pls_tick, unit_tick, step;
	assign sec_tick  = sec_cnt_r == SECW'(SEC_CYCLES - 1);
	assign min_tick  = sec_tick && min_cnt_r == MINW'(MIN_SECS - 1);
	assign pls_tick  = pls_cnt_r == PLSW'(PULSE_CYCLES - 1);
	assign unit_tick = ctrl_r[CB_SCALE +: 2] == SC_HM ? min_tick : sec_tick;
	// A pause keeps the count; timing resumes from it when the input returns.
	assign step = unit_tick && run_lvl && !halt_r && state_r == ST_RUN;
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			sec_cnt_r <= '0;
			min_cnt_r <= '0;
			pls_cnt_r <= '0;
		end else begin
			sec_cnt_r <= sec_tick ? '0 : sec_cnt_r + SECW'(1);
			pls_cnt_r <= pls_tick ? '0 : pls_cnt_r + PLSW'(1);
			if (sec_tick) min_cnt_r <= min_tick ? '0 : min_cnt_r + MINW'(1);
		end
	end

	// ==========================================================
	// Count stepping and setpoint compare
	function automatic logic [CW-1:0] sptmr_step(input logic [CW-1:0] v, input logic dn,
			input logic sx);
		logic [CW-1:0] r;
		r = v + CW'(1);
		if (!dn && sx && v[LO_W-1:0] == LO_MAX) begin
			r = {v[CW-1:LO_W] + (CW-LO_W)'(1), LO_W'(0)};
		end else if (dn) begin
			if (v == '0) r = v;
			else if (sx && v[LO_W-1:0] == '0) r = {v[CW-1:LO_W] - (CW-LO_W)'(1), LO_MAX};
			else r = v - CW'(1);
		end
		return r;
	endfunction : sptmr_step

	logic [CW-1:0] cnt_step, start_val, end_val;
	logic          hit1_ev, hit2_ev, any_rst, mr_hold;
	assign cnt_step  = sptmr_step(count_r, down, sexa);
	assign start_val = down ? sp2_r : SP_RST;
	assign end_val   = down ? SP_RST : sp2_r;
	assign hit1_ev   = step && cnt_step == sp1_r;
	assign hit2_ev   = step && cnt_step == end_val;
	assign any_rst   = mrst_ev || soft_rst;
	assign mr_hold   = (mode == MD_MR1 || mode == MD_MR2) && !alarm2;

	// ==========================================================
	// Reset modes
	always_comb begin
		count_nxt = count_r;
		total_nxt = total_r;
		act_nxt   = act_r;
		halt_nxt  = halt_r;
		show_nxt  = show_r;
		if (any_rst) begin
			count_nxt = start_val;
			act_nxt   = 2'b00;
			halt_nxt  = 1'b0;
			show_nxt  = 1'b0;
		end else if (state_r == ST_LD_CNT) begin
			count_nxt = memif.rdata[CW-1:0];
		end else if (state_r == ST_LD_TOT) begin
			total_nxt = memif.rdata;
		end else begin
			if (step) count_nxt = cnt_step;
			if (hit1_ev && mode != MD_AR5) act_nxt[0] = 1'b1;
			if (hit2_ev) begin
				act_nxt[1] = mode != MD_AR5;
				case (mode)
					MD_MR2: halt_nxt = 1'b1;
					MD_AR2: halt_nxt = 1'b1;
					MD_AR1: begin
						total_nxt = total_r + DW'(cnt_step);
						count_nxt = start_val;
						act_nxt[0] = act_nxt[0] && alarm1;
					end
					MD_AR3: begin
						count_nxt = start_val;
						show_nxt  = 1'b1;
						act_nxt[0] = act_nxt[0] && alarm1;
					end
					MD_AR5: begin
						act_nxt[0] = ~act_r[0];
						count_nxt  = start_val;
					end
					default: ;
				endcase
			end
			if (p_done[0] && alarm1) act_nxt[0] = 1'b0;
			// Manual modes one and two ignore the pulse time of output two while alarm two is off.
			if (p_done[1] && !mr_hold) begin
				act_nxt[1] = 1'b0;
				case (mode)
					MD_AR2: begin
						halt_nxt  = 1'b0;
						count_nxt = start_val;
						act_nxt[0] = act_nxt[0] && alarm1;
					end
					MD_AR3: show_nxt = 1'b0;
					MD_AR4: begin
						count_nxt = start_val;
						act_nxt[0] = act_nxt[0] && alarm1;
					end
					default: ;
				endcase
			end
		end
	end

	// ==========================================================
	// Pulse timers
	logic [1:0] act_start;
	assign act_start = act_nxt & ~act_r;
	for (genvar i = 0; i < 2; i++) begin : g_pulse
		logic [PW-1:0] pcnt_r;
		logic [PW-1:0] ptime;
		assign ptime = i == 0 ? pt1_r : pt2_r;
		// A zero pulse time never expires, so the output holds indefinitely.
		assign p_done[i] = act_r[i] && ptime != PT_RST && pls_tick && pcnt_r == ptime - PT_ONE;
		always_ff @(posedge core_clk_i) begin
			if (!resetn_i || !act_r[i] || act_start[i]) pcnt_r <= PT_RST;
			else if (pls_tick && pcnt_r != ptime) pcnt_r <= pcnt_r + PT_ONE;
		end
	end

	// ==========================================================
	// Back-up sequencing
	sptmr_backup_mem u_mem (
		.core_clk_i (core_clk_i),
		.mem_if     (memif)
	);
	// Without back-up the marker is wiped, so nothing is restored next time.
	assign memif.wr_en = (state_r == ST_RUN && pf_ev) || state_r == ST_SV_TOT ||
		state_r == ST_SV_KEY;
	// Reads are registered: each state sets the address of the word the next state takes.
	assign memif.addr  = (state_r == ST_RD_KEY || state_r == ST_SV_KEY) ? MEM_KEY :
		(state_r == ST_LD_CNT || state_r == ST_SV_TOT) ? MEM_TOT : MEM_CNT;
	assign memif.wdata = state_r == ST_SV_TOT ? total_r :
		state_r == ST_SV_KEY ? (bk_en ? SAVE_KEY : DW_ZERO) : DW'(count_r);
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_RD_KEY: state_nxt = ST_CHK;
			ST_CHK: begin
				// A memory that was never written must fall through to a cold start.
				if (memif.rdata == SAVE_KEY) state_nxt = ST_LD_CNT;
				else state_nxt = ST_RUN;
			end
			ST_LD_CNT: state_nxt = ST_LD_TOT;
			ST_LD_TOT: state_nxt = ST_RUN;
			ST_RUN:    state_nxt = pf_ev ? (bk_en ? ST_SV_TOT : ST_SV_KEY) : ST_RUN;
			ST_SV_TOT: state_nxt = ST_SV_KEY;
			ST_SV_KEY: state_nxt = ST_RUN;
			default:   state_nxt = ST_RUN;
		endcase
	end

	// ==========================================================
	// Core state, status and outputs
	assign events = {1'b0, p_done[1], p_done[0], hit2_ev, hit1_ev} |
		{(wr_sp1 || wr_sp2) && !sp_ok, 4'h0};
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			count_r     <= SP_RST;
			total_r     <= DW_ZERO;
			act_r       <= 2'b00;
			halt_r      <= 1'b0;
			show_r      <= 1'b0;
			state_r     <= ST_RD_KEY;
			status_r    <= ST_RST;
			reg_rdata_o <= DW_ZERO;
			out1_o      <= 1'b0;
			out2_o      <= 1'b0;
			disp_o      <= SP_RST;
			irq_o       <= 1'b0;
		end else begin
			count_r     <= count_nxt;
			total_r     <= total_nxt;
			act_r       <= act_nxt;
			halt_r      <= halt_nxt;
			show_r      <= show_nxt;
			state_r     <= state_nxt;
			// A new event outranks a clear written in the same cycle.
			status_r    <= (status_r & ~(wr_stat ? reg_wdata_i[ST_W-1:0] : ST_RST)) | events;
			reg_rdata_o <= reg_rd_i ? rdata_nxt : DW_ZERO;
			out1_o      <= act_nxt[0] ^ ctrl_r[CB_NE1];
			out2_o      <= act_nxt[1] ^ ctrl_r[CB_NE2];
			disp_o      <= show_nxt ? sp2_r : count_nxt;
			irq_o       <= |((status_r | events) & mask_r);
		end
	end

	// ==========================================================
	// Checks
	a_hit_sets_out1: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		hit1_ev && mode != MD_AR5 && !any_rst |=> act_r[0]) else $error("out1 not set on hit");
	a_hm_sp_limit: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		wr_sp1 && sexa && reg_wdata_i[LO_W-1:0] > LO_MAX |=> $stable(sp1_r))
		else $error("minutes above limit taken");
	a_sec_sp_limit: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		wr_sp2 && !sexa && reg_wdata_i[CW-1:0] > SEC_MAX |=> $stable(sp2_r))
		else $error("seconds setpoint above limit taken");
	a_mr2_halt_holds: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		hit2_ev && mode == MD_MR2 && !any_rst ##1 !any_rst |=> halt_r && $stable(count_r))
		else $error("halt not kept");
	a_ar1_restart: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		hit2_ev && mode == MD_AR1 && !any_rst |=>
		count_r == $past(start_val) && total_r == $past(total_r) + DW'($past(cnt_step)))
		else $error("auto one restart wrong");
	a_ar2_hold: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		halt_r && mode == MD_AR2 && !p_done[1] && !any_rst && state_r == ST_RUN
		|=> $stable(count_r)) else $error("count moved while held");
	a_ar3_display: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		hit2_ev && mode == MD_AR3 && !any_rst |=> disp_o == $past(sp2_r))
		else $error("setpoint not shown");
	a_ar5_toggle: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		hit2_ev && mode == MD_AR5 && !any_rst |=> act_r[0] != $past(act_r[0]))
		else $error("out1 not toggled");
	a_reset_load: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		mrst_ev |=> count_r == $past(start_val) && act_r == 2'b00)
		else $error("reset load wrong");
	a_pause_freeze: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		!run_lvl && state_r == ST_RUN && !any_rst && !p_done[1] |=> $stable(count_r))
		else $error("count moved during pause");
	a_alarm_end: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		p_done[0] && alarm1 && !hit1_ev && !any_rst |=> !act_r[0] ##1 out1_o == ctrl_r[CB_NE1])
		else $error("alarm output not released");
endmodule : sptmr_top

// ### rtl/sptmr_pkg.sv
// Constants, field layouts and types shared by the setpoint timer files.
package sptmr_pkg;
	// ==========================================================
	// Clock and time bases
	localparam int CLK_HZ        = 40_000_000;
	localparam int SEC_UNIT_S    = 1;
	localparam int PULSE_UNIT_MS = 10;
	localparam int MS_PER_S      = 1000;
	localparam int MIN_SECS      = 60;
	// ==========================================================
	// Widths
	localparam int DW        = 24;
	localparam int AW        = 4;
	localparam int CW        = 17;
	localparam int LO_W      = 7;
	localparam int PW        = 14;
	localparam int SECW      = 26;
	localparam int PLSW      = 19;
	localparam int MINW      = 6;
	localparam int MA_W      = 2;
	localparam int MEM_DEPTH = 4;
	localparam int ST_W      = 5;
	localparam int CTRL_W    = 11;
	// ==========================================================
	// Register offsets
	localparam logic [AW-1:0] A_CTRL   = 4'h0;
	localparam logic [AW-1:0] A_SP1    = 4'h1;
	localparam logic [AW-1:0] A_SP2    = 4'h2;
	localparam logic [AW-1:0] A_PT1    = 4'h3;
	localparam logic [AW-1:0] A_PT2    = 4'h4;
	localparam logic [AW-1:0] A_COUNT  = 4'h5;
	localparam logic [AW-1:0] A_TOTAL  = 4'h6;
	localparam logic [AW-1:0] A_STATUS = 4'h7;
	localparam logic [AW-1:0] A_MASK   = 4'h8;
	localparam logic [AW-1:0] A_STATE  = 4'h9;
	// ==========================================================
	// Control fields
	localparam int CB_MODE  = 0;
	localparam int CB_SCALE = 3;
	localparam int CB_DOWN  = 5;
	localparam int CB_NE1   = 6;
	localparam int CB_NE2   = 7;
	localparam int CB_AL1   = 8;
	localparam int CB_AL2   = 9;
	localparam int CB_BKEN  = 10;
	localparam int CB_SRST  = 11;
	localparam logic DIR_UP   = 1'b0;
	localparam logic DIR_DOWN = 1'b1;
	// ==========================================================
	// Limits and reset values
	localparam logic [CW-LO_W-1:0] HM_HI_MAX = 10'h063;
	localparam logic [LO_W-1:0]    LO_MAX    = 7'h3B;
	localparam logic [CW-1:0]      SEC_MAX   = 17'h1869F;
	localparam logic [PW-1:0]      PT_MAX    = 14'h270F;
	localparam logic [CTRL_W-1:0]  CTRL_RST  = 11'h000;
	localparam logic [CW-1:0]      SP_RST    = 17'h00000;
	localparam logic [PW-1:0]      PT_RST    = 14'h0000;
	localparam logic [PW-1:0]      PT_ONE    = 14'h0001;
	localparam logic [ST_W-1:0]    ST_RST    = 5'h00;
	localparam logic [DW-1:0]      DW_ZERO   = 24'h000000;
	// ==========================================================
	// Status bits
	localparam int SB_HIT1 = 0;
	localparam int SB_HIT2 = 1;
	localparam int SB_END1 = 2;
	localparam int SB_END2 = 3;
	localparam int SB_REJ  = 4;
	// ==========================================================
	// Back-up memory layout; the marker value is arbitrary.
	localparam logic [MA_W-1:0] MEM_CNT  = 2'h0;
	localparam logic [MA_W-1:0] MEM_TOT  = 2'h1;
	localparam logic [MA_W-1:0] MEM_KEY  = 2'h2;
	localparam logic [DW-1:0]   SAVE_KEY = 24'hA5C35A;
	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		MD_MR1 = 3'b000, MD_MR2 = 3'b001, MD_MR3 = 3'b010, MD_AR1 = 3'b011,
		MD_AR2 = 3'b100, MD_AR3 = 3'b101, MD_AR4 = 3'b110, MD_AR5 = 3'b111
	} sptmr_mode_t;
	typedef enum logic [1:0] {
		SC_HM = 2'b00, SC_MS = 2'b01, SC_SEC = 2'b10, SC_RSV = 2'b11
	} sptmr_scale_t;
	typedef enum logic [2:0] {
		ST_RD_KEY = 3'b000, ST_CHK = 3'b001, ST_LD_CNT = 3'b010, ST_LD_TOT = 3'b011,
		ST_RUN = 3'b100, ST_SV_TOT = 3'b101, ST_SV_KEY = 3'b110
	} sptmr_state_t;
endpackage : sptmr_pkg

// ### rtl/sptmr_mem_if.sv
// Connection between the timer core and its back-up memory.
`timescale 1ns/1ps
interface sptmr_mem_if;
	import sptmr_pkg::*;
	logic            wr_en;
	logic [MA_W-1:0] addr;
	logic [DW-1:0]   wdata;
	logic [DW-1:0]   rdata;
	modport ctl (output wr_en, output addr, output wdata, input rdata);
	modport mem (input wr_en, input addr, input wdata, output rdata);
endinterface : sptmr_mem_if

// ### rtl/sptmr_backup_mem.sv
// Small retained memory holding the count across a power loss.
`timescale 1ns/1ps
module sptmr_backup_mem (
	input wire logic    core_clk_i,
	sptmr_mem_if.mem    mem_if
);
	import sptmr_pkg::*;
	// ==========================================================
	// Storage
	// No reset on purpose: the contents must survive a reset of the core.
	logic [DW-1:0] store_r [MEM_DEPTH];
	always_ff @(posedge core_clk_i) begin
		if (mem_if.wr_en) begin
			store_r[mem_if.addr] <= mem_if.wdata;
		end
		mem_if.rdata <= store_r[mem_if.addr];
	end
endmodule : sptmr_backup_mem

// ### dv/sptmr_panel.sv
// Field-side model: start switch, manual reset button and supply monitor.
`timescale 1ns/1ps
module sptmr_panel (
	input  wire logic core_clk_i,
	input  wire logic out1_i,
	input  wire logic out2_i,
	output logic      run_o,
	output logic      man_reset_o,
	output logic      power_fail_o
);
	// ==========================================================
	// Pin drive
	initial begin
		run_o = 1'b0;
		man_reset_o = 1'b0;
		power_fail_o = 1'b0;
	end
	// ==========================================================
	// Relay contacts
	// Each closing is counted so the bench can see how often a relay pulled in.
	int         closes1 = 0;
	int         closes2 = 0;
	logic [1:0] relay_q = 2'b00;
	always @(posedge core_clk_i) begin
		relay_q <= {out2_i, out1_i};
		if (out1_i && !relay_q[0]) closes1 <= closes1 + 1;
		if (out2_i && !relay_q[1]) closes2 <= closes2 + 1;
	end
	// Waits cover the two-flop synchroniser so the edge is seen before return.
	task set_run(input logic on);
		@(posedge core_clk_i);
		run_o <= on;
		repeat (5) @(posedge core_clk_i);
	endtask : set_run
	task pulse_reset;
		@(posedge core_clk_i);
		man_reset_o <= 1'b1;
		repeat (4) @(posedge core_clk_i);
		man_reset_o <= 1'b0;
		repeat (4) @(posedge core_clk_i);
	endtask : pulse_reset
	task pulse_fail;
		@(posedge core_clk_i);
		power_fail_o <= 1'b1;
		repeat (4) @(posedge core_clk_i);
		power_fail_o <= 1'b0;
		repeat (8) @(posedge core_clk_i);
	endtask : pulse_fail
endmodule : sptmr_panel

// ### dv/sptmr_tb.sv
// Self-checking bench of the setpoint timer through its register port and pins.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fails++; \
	$display("BAD %s expected %h seen %h", nm, ex, got); end end
module testbench;
	import sptmr_pkg::*;
	localparam int LIMIT = 20000;
	logic          core_clk_i, resetn_i, reg_wr_i, reg_rd_i;
	logic [AW-1:0] reg_addr_i;
	logic [DW-1:0] reg_wdata_i;
	logic [DW-1:0] reg_rdata_o;
	logic [CW-1:0] disp_o;
	logic          run_i, man_reset_i, power_fail_i, out1_o, out2_o, irq_o;
	logic [DW-1:0] saved;
	int            n2;
	int            fails = 0;
	int            n_tests = 0;
	int            cyc = 0;
	always #12.5 core_clk_i = ~core_clk_i;
	sptmr_top #(.SEC_CYCLES(20), .PULSE_CYCLES(4)) sptmr_top_inst (
		.core_clk_i(core_clk_i), .resetn_i(resetn_i), .run_i(run_i),
		.man_reset_i(man_reset_i), .power_fail_i(power_fail_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .out1_o(out1_o), .out2_o(out2_o), .disp_o(disp_o),
		.irq_o(irq_o));
	sptmr_panel sptmr_panel_inst (
		.core_clk_i(core_clk_i), .out1_i(out1_o), .out2_i(out2_o), .run_o(run_i),
		.man_reset_o(man_reset_i), .power_fail_o(power_fail_i));
	// ==========================================================
	// Register port
	task wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
		@(posedge core_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= v;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
		@(posedge core_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1 v = reg_rdata_o;
	endtask : rd
	task chk(input string nm, input logic [AW-1:0] a, input logic [DW-1:0] ex);
		logic [DW-1:0] v;
		rd(a, v);
		`CHK(nm, ex, v)
	endtask : chk
	// Polls a status bit with a bounded number of reads.
	task wait_bit(input int b);
		logic [DW-1:0] v;
		v = '0;
		for (int i = 0; i < 300 && !v[b]; i++) rd(A_STATUS, v);
		`CHK("status wait", 1'b1, v[b])
	endtask : wait_bit
	task give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			fails++;
			give_verdict();
		end
	end
	// ==========================================================
	// Tests
	initial begin
		core_clk_i = 1'b0;
		resetn_i = 1'b0;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		reg_addr_i = '0;
		reg_wdata_i = '0;
		repeat (2) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		repeat (6) @(posedge core_clk_i);
		for (int a = 0; a < 9; a++) chk("reset reg", a[AW-1:0], DW_ZERO);
		chk("unmapped", 4'hF, DW_ZERO);
		`CHK("out1 idle", 1'b0, out1_o)
		`CHK("irq idle", 1'b0, irq_o)
		$display("test reset done");
		wr(A_CTRL, 24'h000010);
		wr(A_SP2, 24'h01869F);
		chk("sp2 max", A_SP2, 24'h01869F);
		wr(A_SP2, 24'h0186A0);
		chk("sp2 over", A_SP2, 24'h01869F);
		chk("refused", A_STATUS, 24'h000010);
		wr(A_STATUS, 24'h000010);
		wr(A_CTRL, 24'h000000);
		wr(A_SP1, 24'h00003C);
		chk("sp1 min60", A_SP1, 24'h000000);
		wr(A_SP1, 24'h0031BB);
		chk("sp1 max", A_SP1, 24'h0031BB);
		wr(A_PT1, 24'h002710);
		chk("pt over", A_PT1, 24'h000000);
		wr(A_PT1, 24'h00270F);
		chk("pt max", A_PT1, 24'h00270F);
		wr(A_STATUS, 24'h00001F);
		$display("test ranges done");
		// Manual mode two halts at the second setpoint; output two holds.
		wr(A_CTRL, 24'h000011);
		wr(A_SP1, 24'h000001);
		wr(A_SP2, 24'h000003);
		wr(A_PT2, 24'h000001);
		wr(A_MASK, 24'h000002);
		sptmr_panel_inst.set_run(1'b1);
		wait_bit(SB_HIT2);
		`CHK("irq set", 1'b1, irq_o)
		repeat (60) @(posedge core_clk_i);
		chk("halted", A_COUNT, 24'h000003);
		`CHK("out1 on", 1'b1, out1_o)
		`CHK("relay1 closes", 1, sptmr_panel_inst.closes1)
		`CHK("out2 held", 1'b1, out2_o)
		wr(A_STATUS, 24'h00001F);
		repeat (2) @(posedge core_clk_i);
		`CHK("irq clear", 1'b0, irq_o)
		sptmr_panel_inst.set_run(1'b0);
		sptmr_panel_inst.pulse_reset();
		chk("reset up", A_COUNT, 24'h000000);
		`CHK("out2 off", 1'b0, out2_o)
		repeat (60) @(posedge core_clk_i);
		chk("paused", A_COUNT, 24'h000000);
		$display("test manual done");
		// Downward counting reloads setpoint two and runs to zero.
		wr(A_CTRL, 24'h000031);
		sptmr_panel_inst.pulse_reset();
		chk("reset down", A_COUNT, 24'h000003);
		sptmr_panel_inst.set_run(1'b1);
		wait_bit(SB_HIT2);
		chk("down end", A_COUNT, 24'h000000);
		sptmr_panel_inst.set_run(1'b0);
		wr(A_CTRL, 24'h000051);
		sptmr_panel_inst.pulse_reset();
		`CHK("out1 ne", 1'b1, out1_o)
		`CHK("out2 nd", 1'b0, out2_o)
		$display("test direction done");
		// Automatic mode one adds each cycle to the total.
		wr(A_CTRL, 24'h000013);
		wr(A_STATUS, 24'h00001F);
		sptmr_panel_inst.pulse_reset();
		sptmr_panel_inst.set_run(1'b1);
		wait_bit(SB_HIT2);
		chk("total one", A_TOTAL, 24'h000003);
		wr(A_STATUS, 24'h000002);
		wait_bit(SB_HIT2);
		chk("total two", A_TOTAL, 24'h000006);
		$display("test auto done");
		// Auto three shows setpoint two during the pulse, then the new count.
		wr(A_CTRL, 24'h000015);
		wr(A_PT2, 24'h000006);
		sptmr_panel_inst.pulse_reset();
		wr(A_STATUS, 24'h00001F);
		n2 = sptmr_panel_inst.closes2;
		wait_bit(SB_HIT2);
		`CHK("disp sp2", 17'h00003, disp_o)
		chk("count cleared", A_COUNT, 24'h000000);
		wait_bit(SB_END2);
		`CHK("disp count", 17'h00001, disp_o)
		`CHK("out2 ended", 1'b0, out2_o)
		`CHK("relay2 closes", n2 + 1, sptmr_panel_inst.closes2)
		// Auto four counts past setpoint two and restarts at pulse end.
		wr(A_CTRL, 24'h000016);
		sptmr_panel_inst.pulse_reset();
		wr(A_STATUS, 24'h00001F);
		wait_bit(SB_END2);
		chk("ar4 restart", A_COUNT, 24'h000000);
		// Manual three releases output two when its pulse ends.
		wr(A_CTRL, 24'h000012);
		sptmr_panel_inst.pulse_reset();
		wr(A_STATUS, 24'h00001F);
		wait_bit(SB_END2);
		`CHK("mr3 out2", 1'b0, out2_o)
		$display("test modes done");
		// A paused count survives a power loss only with back-up on.
		wr(A_CTRL, 24'h000410);
		sptmr_panel_inst.pulse_reset();
		repeat (50) @(posedge core_clk_i);
		sptmr_panel_inst.set_run(1'b0);
		rd(A_COUNT, saved);
		sptmr_panel_inst.pulse_fail();
		resetn_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		repeat (8) @(posedge core_clk_i);
		chk("restored", A_COUNT, saved);
		sptmr_panel_inst.pulse_fail();
		resetn_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		repeat (8) @(posedge core_clk_i);
		chk("not kept", A_COUNT, 24'h000000);
		$display("test backup done");
		give_verdict();
	end
endmodule : testbench
